// ==== inc/bit_flag_branch_exec_defs.vh ====
// constants shared by the bit, flag and branch execution unit
`ifndef BIT_FLAG_BRANCH_EXEC_DEFS_VH
`define BIT_FLAG_BRANCH_EXEC_DEFS_VH

// ==========================================================
// instruction word layout
`define INSTR_W          16
`define OP_MSB           15
`define OP_LSB           11
`define BIT_MSB          10
`define BIT_LSB          8
`define OPND_MSB         7
`define OPND_LSB         0
`define REG_IDX_W        5
`define IO_IDX_W         6
`define NUM_GPR          32
`define NUM_IO           64

// ==========================================================
// opcodes
`define OP_W             5
`define OP_NOP           5'h00
`define OP_BR_T_CLR      5'h01
`define OP_BR_V_SET      5'h02
`define OP_BR_V_CLR      5'h03
`define OP_BR_I_ON       5'h04
`define OP_BR_I_OFF      5'h05
`define OP_IO_SET        5'h06
`define OP_IO_CLR        5'h07
`define OP_SHL           5'h08
`define OP_SHR           5'h09
`define OP_ROL           5'h0A
`define OP_ROR           5'h0B
`define OP_ASR           5'h0C
`define OP_COPY_TO_T     5'h0D
`define OP_LOAD_FROM_T   5'h0E
`define OP_FLAG_SET      5'h0F
`define OP_FLAG_CLR      5'h10

// ==========================================================
// condition flag positions
`define FLG_C            0
`define FLG_Z            1
`define FLG_N            2
`define FLG_V            3
`define FLG_S            4
`define FLG_H            5
`define FLG_T            6
`define FLG_I            7

// ==========================================================
// reset values
`define FLAGS_RST        8'h00
`define DATA_RST         8'h00
`define PC_RST           16'h0000

`endif

// ==== design/shift_flag_unit.v ====
// shift and rotate datapath with its flag results
`timescale 1ns/100ps
`default_nettype none
`include "bit_flag_branch_exec_defs.vh"

module shift_flag_unit (
   input  wire [`OP_W-1:0] op,
   input  wire [7:0]       din,
   input  wire             carry_in,
   output reg  [7:0]       dout,
   output reg              flag_z,
   output reg              flag_c,
   output reg              flag_n,
   output reg              flag_v
);

   always @* begin
      dout   = din;
      flag_c = 1'b0;
      case (op)
         `OP_SHL: begin
            dout   = {din[6:0], 1'b0};     // [RL6]
            flag_c = din[7];
         end
         `OP_SHR: begin
            dout   = {1'b0, din[7:1]};     // [RL7]
            flag_c = din[0];
         end
         `OP_ROL: begin
            dout   = {din[6:0], carry_in}; // [RL8]
            flag_c = din[7];
         end
         `OP_ROR: begin
            dout   = {carry_in, din[7:1]}; // [RL9]
            flag_c = din[0];
         end
         `OP_ASR: begin
            dout   = {din[7], din[7:1]};   // [RL10]
            flag_c = din[0];
         end
         default: begin
            dout   = din;
            flag_c = carry_in;
         end
      endcase
      flag_z = (dout == 8'h00);
      flag_n = dout[7];
      // overflow reported as n xor c after the shift
      flag_v = dout[7] ^ flag_c;
   end

endmodule
`default_nettype wire

// ==== design/bit_flag_branch_exec.v ====
// execution unit for flag branches, i/o bit ops, shifts and flag ops
//
// What this block does
// [RL1] Branch on transfer clear jumps to pc plus offset plus one when t is 0, one cycle untaken, two taken, no flag change.
// [RL2] Overflow branches jump to pc plus offset plus one on v set or clear, one or two cycles, no flag change.
// [RL3] Interrupt branches jump to pc plus offset plus one on i set or clear, one or two cycles, no flag change.
// [RL4] The i/o bit set writes one to the chosen i/o bit, keeps the rest, takes two cycles and keeps flags.
// [RL5] The i/o bit clear writes zero to the chosen i/o bit, keeps the rest, takes two cycles and keeps flags.
// [RL6] Logical left shift moves bits up, puts zero in bit 0 and updates z, c, n, v in one cycle.
// [RL7] Logical right shift moves bits down, puts zero in bit 7 and updates z, c, n, v in one cycle.
// [RL8] Rotate left moves old carry into bit 0 and old bit 7 into carry, updating z, c, n, v in one cycle.
// [RL9] Rotate right moves old carry into bit 7 and old bit 0 into carry, updating z, c, n, v in one cycle.
// [RL10] Arithmetic right shift moves bits down keeping bit 7, updating z, c, n, v in one cycle.
// [RL11] Copy bit to flag puts the chosen register bit into t in one cycle, touching no other flag.
// [RL12] Load bit from flag writes t into the chosen register bit in one cycle, touching nothing else.
// [RL13] Each flag set instruction sets exactly one flag to one in one cycle.
// [RL14] Each flag clear instruction clears exactly one flag to zero in one cycle.
`timescale 1ns/100ps
`default_nettype none
`include "bit_flag_branch_exec_defs.vh"

module bit_flag_branch_exec #(
   parameter PC_W = 16
) (
   input  wire                  clk,
   input  wire                  resetn,
   input  wire                  ce,
   input  wire                  instr_valid,
   input  wire [`INSTR_W-1:0]   instr_word,
   input  wire [`REG_IDX_W-1:0] reg_rd_addr,
   input  wire [`IO_IDX_W-1:0]  io_rd_addr,
   output reg                   instr_ready_q,
   output reg  [PC_W-1:0]       pc_q,
   output reg  [7:0]            flags_q,
   output reg  [7:0]            reg_rd_data_q,
   output reg  [7:0]            io_rd_data_q
);

   // ==========================================================
   // state and storage
   localparam [1:0] ST_RUN = 2'b01;
   localparam [1:0] ST_FIN = 2'b10;

   reg [1:0]            state_q;
   reg [1:0]            state_d;
   reg [7:0]            gpr_q [0:`NUM_GPR-1];
   reg [7:0]            io_q  [0:`NUM_IO-1];
   reg [`OP_W-1:0]      hold_op_q;
   reg [2:0]            hold_bit_q;
   reg [`IO_IDX_W-1:0]  hold_io_q;
   reg [7:0]            rmw_q;
   reg [PC_W-1:0]       target_q;
   integer              i;

   // one-hot mask of a bit position
   function [7:0] bit_mask;
      input [2:0] b;
      begin
         bit_mask = 8'h01 << b;
      end
   endfunction

   // value with one bit forced to the given level
   function [7:0] bit_write;
      input [7:0] val;
      input [2:0] b;
      input       lvl;
      begin
         if (lvl)
            bit_write = val | bit_mask(b);
         else
            bit_write = val & ~bit_mask(b);
      end
   endfunction

   // ==========================================================
   // decode
   wire [`OP_W-1:0]      op     = instr_word[`OP_MSB:`OP_LSB];
   wire [2:0]            bsel   = instr_word[`BIT_MSB:`BIT_LSB];
   wire [7:0]            opnd   = instr_word[`OPND_MSB:`OPND_LSB];
   wire [`REG_IDX_W-1:0] ridx   = opnd[`REG_IDX_W-1:0];
   wire [`IO_IDX_W-1:0]  iidx   = opnd[`IO_IDX_W-1:0];
   wire [7:0]            rval   = gpr_q[ridx];
   wire [7:0]            mask   = bit_mask(bsel);
   wire                  accept = ce & instr_valid & instr_ready_q &
                                  (state_q == ST_RUN);

   // branch offset counts from the word after the branch
   wire [PC_W-1:0] pc_next   = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
   wire [PC_W-1:0] br_target = pc_next + {{(PC_W-8){opnd[7]}}, opnd};

   reg br_op;
   reg br_cond;
   always @* begin
      br_op   = 1'b1;
      br_cond = 1'b0;
      case (op)
         `OP_BR_T_CLR: br_cond = ~flags_q[`FLG_T]; // [RL1]
         `OP_BR_V_SET: br_cond =  flags_q[`FLG_V]; // [RL2]
         `OP_BR_V_CLR: br_cond = ~flags_q[`FLG_V]; // [RL2]
         `OP_BR_I_ON:  br_cond =  flags_q[`FLG_I]; // [RL3]
         `OP_BR_I_OFF: br_cond = ~flags_q[`FLG_I]; // [RL3]
         default:      br_op   = 1'b0;
      endcase
   end

   // unknown opcodes fall through as one-cycle no-ops
   wire is_io   = (op == `OP_IO_SET) | (op == `OP_IO_CLR);
   wire two_cyc = (br_op & br_cond) | is_io;

   // ==========================================================
   // shift datapath
   // purely combinational; its result lands on the take edge
   wire [7:0] sh_dout;
   wire       sh_z;
   wire       sh_c;
   wire       sh_n;
   wire       sh_v;
   wire       is_shift = (op == `OP_SHL) | (op == `OP_SHR) |
                         (op == `OP_ROL) | (op == `OP_ROR) |
                         (op == `OP_ASR);

   shift_flag_unit u_shift (
      .op       (op),
      .din      (rval),
      .carry_in (flags_q[`FLG_C]),
      .dout     (sh_dout),
      .flag_z   (sh_z),
      .flag_c   (sh_c),
      .flag_n   (sh_n),
      .flag_v   (sh_v)
   );

   // ==========================================================
   // flag update, one bit at a time
   // flags move only on the take edge; the second cycle of a
   // two-cycle op leaves them alone
   wire       set_op   = (op == `OP_FLAG_SET);
   wire       clr_op   = (op == `OP_FLAG_CLR);
   wire       copy_op  = (op == `OP_COPY_TO_T);
   wire [7:0] sh_flags = {flags_q[7:4], sh_v, sh_n, sh_z, sh_c};
   wire [7:0] flags_d;
   genvar     g;

   // set and clear name their flag with the same select field as bit ops
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_flag
         assign flags_d[g] =
            (set_op & mask[g])       ? 1'b1        : // [RL13]
            (clr_op & mask[g])       ? 1'b0        : // [RL14]
            (copy_op && g == `FLG_T) ? rval[bsel]  : // [RL11]
            is_shift                 ? sh_flags[g] : // [RL6]
            flags_q[g];
      end
   endgenerate

   // ==========================================================
   // sequencing
   // st_fin is the extra cycle of taken branches and i/o writes
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN:  if (accept && two_cyc) state_d = ST_FIN;
         ST_FIN:  if (ce) state_d = ST_RUN;
         default: state_d = ST_RUN;
      endcase
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q       <= ST_RUN;
         instr_ready_q <= 1'b0;
         pc_q          <= `PC_RST;
         flags_q       <= `FLAGS_RST;
         reg_rd_data_q <= `DATA_RST;
         io_rd_data_q  <= `DATA_RST;
         hold_op_q     <= `OP_NOP;
         hold_bit_q    <= 3'h0;
         hold_io_q     <= {`IO_IDX_W{1'b0}};
         rmw_q         <= `DATA_RST;
         target_q      <= `PC_RST;
         for (i = 0; i < `NUM_GPR; i = i + 1)
            gpr_q[i] <= `DATA_RST;
         for (i = 0; i < `NUM_IO; i = i + 1)
            io_q[i] <= `DATA_RST;
      end else if (ce) begin
         state_q       <= state_d;
         // read ports show contents before this edge's write
         reg_rd_data_q <= gpr_q[reg_rd_addr];
         io_rd_data_q  <= io_q[io_rd_addr];
         // ready drops for the one extra cycle of two-cycle work
         instr_ready_q <= (state_q == ST_FIN) | ~(accept & two_cyc);
         // i/o write-back uses the value read at take, so a debug read
         // in between still shows the old value
         if (state_q == ST_FIN) begin
            case (hold_op_q)
               `OP_IO_SET: begin
                  io_q[hold_io_q] <= rmw_q | bit_mask(hold_bit_q);   // [RL4]
                  pc_q            <= target_q;
               end
               `OP_IO_CLR: begin
                  io_q[hold_io_q] <= rmw_q & ~bit_mask(hold_bit_q);  // [RL5]
                  pc_q            <= target_q;
               end
               default: pc_q <= target_q; // [RL1] [RL2] [RL3]
            endcase
         end else if (accept) begin
            hold_op_q  <= op;
            hold_bit_q <= bsel;
            hold_io_q  <= iidx;
            rmw_q      <= io_q[iidx];
            target_q   <= (br_op & br_cond) ? br_target : pc_next;
            flags_q    <= flags_d;
            if (!two_cyc)
               pc_q <= pc_next; // [RL1] [RL2] [RL3]
            if (is_shift)
               gpr_q[ridx] <= sh_dout; // [RL6] [RL7] [RL8] [RL9] [RL10]
            else if (op == `OP_LOAD_FROM_T)
               gpr_q[ridx] <= bit_write(rval, bsel, flags_q[`FLG_T]); // [RL12]
         end
      end
   end

endmodule
`default_nettype wire

// ==== tb/prog_mem_model.sv ====
// program memory model supplying instruction words at the pc
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model (
   input  wire logic [15:0] pc,
   input  wire logic        fetch_en,
   output logic             instr_valid,
   output logic [15:0]      instr_word
);
   logic [15:0] mem [0:255];
   assign instr_valid = fetch_en;
   // idle: inverted word, so a stale value never passes for a fresh one
   assign instr_word = fetch_en ? mem[pc[7:0]] : ~mem[pc[7:0]];
endmodule
`default_nettype wire

// ==== tb/bit_flag_branch_exec_asserts.sv ====
// port checker for the bit, flag and branch execution unit
`timescale 1ns/100ps
`default_nettype none
`include "bit_flag_branch_exec_defs.vh"
module exec_port_checker #(
   parameter PC_W = 16
) (
   input wire logic                  clk,
   input wire logic                  resetn,
   input wire logic                  ce,
   input wire logic                  instr_valid,
   input wire logic [`INSTR_W-1:0]   instr_word,
   input wire logic [`REG_IDX_W-1:0] reg_rd_addr,
   input wire logic [`IO_IDX_W-1:0]  io_rd_addr,
   input wire logic                  instr_ready_q,
   input wire logic [PC_W-1:0]       pc_q,
   input wire logic [7:0]            flags_q,
   input wire logic [7:0]            reg_rd_data_q,
   input wire logic [7:0]            io_rd_data_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire       tk = ce && instr_valid && instr_ready_q;
   wire [4:0] op = instr_word[15:11];
   AST_T_UNTAKEN:
      assert property (tk && op == `OP_BR_T_CLR && flags_q[6]
         |=> instr_ready_q && pc_q == $past(pc_q) + 1) else $error("t br");
   AST_V_TAKEN:
      assert property (tk && op == `OP_BR_V_SET && flags_q[3]
         |=> !instr_ready_q && $stable(pc_q)) else $error("v br");
   AST_KEEP_FLAGS:
      assert property (tk && ((op >= 5'h01 && op <= 5'h05) ||
         op == `OP_LOAD_FROM_T) |=> $stable(flags_q)) else $error("flags");
   AST_IO_TWO:
      assert property (tk && (op == `OP_IO_SET || op == `OP_IO_CLR)
         |=> !instr_ready_q && $stable(flags_q)) else $error("io op");
   AST_SHIFT_V:
      assert property (tk && op >= `OP_SHL && op <= `OP_ASR
         |=> flags_q[3] == (flags_q[2] ^ flags_q[0])
         && flags_q[7:4] == $past(flags_q[7:4])) else $error("shift");
   AST_FLAG_SET:
      assert property (tk && op == `OP_FLAG_SET |=> flags_q ==
         ($past(flags_q) | (8'h01 << $past(instr_word[10:8]))))
         else $error("set");
   AST_FLAG_CLR:
      assert property (tk && op == `OP_FLAG_CLR |=> flags_q ==
         ($past(flags_q) & ~(8'h01 << $past(instr_word[10:8]))))
         else $error("clear");
   AST_COPY_T:
      assert property (tk && op == `OP_COPY_TO_T |=> {flags_q[7],
         flags_q[5:0]} == $past({flags_q[7], flags_q[5:0]}))
         else $error("copy");
   cover property (tk && op == `OP_BR_T_CLR && !flags_q[6]);
   cover property (tk && op == `OP_IO_SET);
   cover property (tk && op == `OP_FLAG_CLR);
endmodule
bind bit_flag_branch_exec exec_port_checker #(.PC_W(PC_W)) chk_inst (
   .clk(clk), .resetn(resetn), .ce(ce), .instr_valid(instr_valid),
   .instr_word(instr_word), .reg_rd_addr(reg_rd_addr),
   .io_rd_addr(io_rd_addr), .instr_ready_q(instr_ready_q), .pc_q(pc_q),
   .flags_q(flags_q), .reg_rd_data_q(reg_rd_data_q),
   .io_rd_data_q(io_rd_data_q));
`default_nettype wire

// ==== tb/bit_flag_branch_exec_tb.sv ====
// self-checking bench for the bit, flag and branch execution unit
`timescale 1ns/100ps
`default_nettype none
`include "bit_flag_branch_exec_defs.vh"
module bit_flag_branch_exec_tb;
   logic        clk = 1'h0;
   logic        resetn = 1'h0;
   logic        fetch_en = 1'h0;
   logic        ce = 1'h1;
   logic [15:0] pw;
   logic [4:0]  reg_rd_addr = 5'h00;
   logic [5:0]  io_rd_addr = 6'h00;
   logic [7:0]  ef;
   wire         instr_valid;
   wire         instr_ready_q;
   wire  [15:0] instr_word;
   wire  [15:0] pc_q;
   wire  [7:0]  flags_q;
   wire  [7:0]  reg_rd_data_q;
   wire  [7:0]  io_rd_data_q;
   integer      err_count = 0;
   integer      num_checks = 0;

   always #2.5 clk = ~clk;

   prog_mem_model prog_mem_model_inst (.pc(pc_q), .fetch_en(fetch_en),
      .instr_valid(instr_valid), .instr_word(instr_word));
   bit_flag_branch_exec #(.PC_W(16)) bit_flag_branch_exec_inst (
      .clk(clk), .resetn(resetn), .ce(ce), .instr_valid(instr_valid),
      .instr_word(instr_word), .reg_rd_addr(reg_rd_addr),
      .io_rd_addr(io_rd_addr), .instr_ready_q(instr_ready_q), .pc_q(pc_q),
      .flags_q(flags_q), .reg_rd_data_q(reg_rd_data_q),
      .io_rd_data_q(io_rd_data_q));

   task automatic chk(input string nm, input [15:0] e, input [15:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wait_rdy(output integer n);
      for (n = 0; instr_ready_q !== 1'h1; n++) begin
         if (n == 20) begin
            err_count++;
            summarize();
         end
         @(posedge clk);
         #1;
      end
   endtask
   // one word per call; the word is placed at the pc just before fetch
   task automatic exec(input [4:0] o, input [2:0] b, input [7:0] d,
      input integer n, input [15:0] off);
      logic [15:0] p;
      integer      c;
      // idle edge first, so fetch_en never rises where it just fell
      @(posedge clk);
      #1;
      wait_rdy(c);
      p = pc_q;
      prog_mem_model_inst.mem[p[7:0]] = {o, b, d};
      fetch_en = 1'h1;
      @(posedge clk);
      #1;
      fetch_en = 1'h0;
      wait_rdy(c);
      chk("cycles", n, c + 1);
      chk("pc", p + 16'h0001 + off, pc_q);
   endtask
   task automatic rd(input [4:0] r, input [5:0] a);
      reg_rd_addr = r;
      io_rd_addr = a;
      @(posedge clk);
      #1;
   endtask
   task automatic sh(input [4:0] o, input [4:0] r, input [7:0] d, f);
      exec(o, 3'h0, {3'h0, r}, 1, 16'h0000);
      rd(r, 6'h00);
      chk("reg", d, reg_rd_data_q);
      chk("flags", f, flags_q);
   endtask
   task automatic br(input [4:0] o, input [7:0] k, input t);
      ef = flags_q;
      exec(o, 3'h0, k, t ? 2 : 1, t ? {{8{k[7]}}, k} : 16'h0000);
      chk("flags", ef, flags_q);
   endtask
   task automatic io(input [4:0] o, input [2:0] b, input [7:0] d);
      ef = flags_q;
      exec(o, b, 8'h3F, 2, 16'h0000);
      rd(5'h00, 6'h3F);
      chk("io", d, io_rd_data_q);
      chk("flags", ef, flags_q);
   endtask

   initial begin
      repeat (10) @(posedge clk);
      #1;
      resetn = 1'h1;
      ef = 8'h00;
      for (int i = 0; i < 16; i++) begin
         exec(i < 8 ? `OP_FLAG_SET : `OP_FLAG_CLR, i[2:0], 8'h00, 1,
            16'h0000);
         ef[i[2:0]] = i < 8;
         chk("flags", ef, flags_q);
      end
      exec(`OP_FLAG_SET, 3'h6, 8'h00, 1, 16'h0000);
      exec(`OP_FLAG_SET, 3'h5, 8'h00, 1, 16'h0000);
      exec(`OP_LOAD_FROM_T, 3'h7, 8'h03, 1, 16'h0000);
      exec(`OP_LOAD_FROM_T, 3'h0, 8'h03, 1, 16'h0000);
      sh(`OP_SHL, 5'h03, 8'h02, 8'h69);
      sh(`OP_ROL, 5'h03, 8'h05, 8'h60);
      sh(`OP_ROR, 5'h03, 8'h02, 8'h69);
      sh(`OP_ROR, 5'h03, 8'h81, 8'h6C);
      sh(`OP_ASR, 5'h03, 8'hC0, 8'h65);
      sh(`OP_SHR, 5'h03, 8'h60, 8'h60);
      sh(`OP_SHL, 5'h04, 8'h00, 8'h62);
      sh(`OP_COPY_TO_T | 5'h00, 5'h03, 8'h60, 8'h22);
      exec(`OP_COPY_TO_T, 3'h7, 8'h03, 1, 16'h0000);
      chk("flags", 8'h22, flags_q);
      exec(`OP_COPY_TO_T, 3'h6, 8'h03, 1, 16'h0000);
      chk("flags", 8'h62, flags_q);
      br(`OP_BR_T_CLR, 8'h10, 1'h0);
      br(`OP_BR_V_SET, 8'h10, 1'h0);
      br(`OP_BR_V_CLR, 8'hFE, 1'h1);
      br(`OP_BR_I_ON, 8'h10, 1'h0);
      br(`OP_BR_I_OFF, 8'h05, 1'h1);
      exec(`OP_FLAG_CLR, 3'h6, 8'h00, 1, 16'h0000);
      exec(`OP_FLAG_SET, 3'h3, 8'h00, 1, 16'h0000);
      exec(`OP_FLAG_SET, 3'h7, 8'h00, 1, 16'h0000);
      br(`OP_BR_T_CLR, 8'h7F, 1'h1);
      br(`OP_BR_V_SET, 8'h80, 1'h1);
      br(`OP_BR_V_CLR, 8'h01, 1'h0);
      br(`OP_BR_I_ON, 8'h03, 1'h1);
      br(`OP_BR_I_OFF, 8'h02, 1'h0);
      io(`OP_IO_SET, 3'h0, 8'h01);
      io(`OP_IO_SET, 3'h7, 8'h81);
      io(`OP_IO_CLR, 3'h0, 8'h80);
      // clock enable low: a waiting word must not be taken
      ef = flags_q;
      pw = pc_q;
      ce = 1'h0;
      prog_mem_model_inst.mem[pw[7:0]] = {`OP_FLAG_SET, 3'h0, 8'h00};
      fetch_en = 1'h1;
      repeat (3) @(posedge clk);
      #1;
      chk("frozen pc", pw, pc_q);
      chk("frozen flags", ef, flags_q);
      ce = 1'h1;
      @(posedge clk);
      #1;
      fetch_en = 1'h0;
      chk("flags", ef | 8'h01, flags_q);
      chk("pc", pw + 16'h0001, pc_q);
      summarize();
   end
endmodule
`default_nettype wire
